// >>> verilog/adcsr_pkg.sv
// adcsr_pkg: shared constants and types for the serial readout block
package adcsr_pkg;

    // ------------------------------------------------------------
    // frame counting
    // ------------------------------------------------------------
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_EDGES = 5'h10; // last falling edge of a frame
    localparam logic [CNT_W-1:0] GLITCH_EDGE = 5'h02; // first edge that may power down
    localparam logic [CNT_W-1:0] COMMIT_EDGE = 5'h0A; // edge that keeps the core powered
    localparam int LEAD_ZEROS = 2;
    localparam int RES_BITS_DEFAULT = 12;
    localparam int FIFO_DEPTH_DEFAULT = 8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 50;
    localparam int WAKE_DELAY_TIME_NS = 1000; // full power-down wake time
    localparam int WAKE_CYCLES = (WAKE_DELAY_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    // ------------------------------------------------------------
    // power modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ADCSR_NORMAL,
        ADCSR_PARTIAL,
        ADCSR_FULL
    } adcsr_mode_t;

    localparam adcsr_mode_t RESET_MODE = ADCSR_NORMAL;

endpackage

// >>> verilog/adcsr_stream_if.sv
// adcsr_stream_if: valid/ready word channel between internal modules
`timescale 1ns/1ps
interface adcsr_stream_if #(
    parameter int W = 12
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> verilog/adcsr_edge.sv
// adcsr_edge: registered edge detection for synchronous pins
`timescale 1ns/1ps
module adcsr_edge #(
    parameter int N = 2,
    parameter logic [N-1:0] INIT = '1
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [N-1:0] pin,
    output logic [N-1:0] rise,
    output logic [N-1:0] fall
);
    logic [N-1:0] prev;

    // ------------------------------------------------------------
    // one stage of history and the edge terms per bit
    // ------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_bit
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                prev[i] <= INIT[i];
            end else if (ce) begin
                prev[i] <= pin[i];
            end
        end
        assign rise[i] = ce & pin[i] & ~prev[i];
        assign fall[i] = ce & ~pin[i] & prev[i];
    end
endmodule

// >>> verilog/adcsr_fifo.sv
// adcsr_fifo: result buffer between the conversion core and the shifter
`timescale 1ns/1ps
module adcsr_fifo #(
    parameter int W = 12,
    parameter int D = 8
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    adcsr_stream_if.src out
);
    localparam int PW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(D);
    localparam logic [PW-1:0] LAST_PTR = PW'(D - 1);

    logic [W-1:0] mem [D];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid & in_ready & ce;
    assign pop = out.valid & out.ready & ce;
    assign out.valid = (count != '0);
    assign out.data = mem[rd_ptr];

    // occupancy after this cycle
    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // storage write
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers, count and registered ready
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
        end else if (ce) begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= (next_count < FULL_COUNT);
        end
    end
endmodule

// >>> verilog/adcsr_top.sv
// adcsr_top: serial readout and power-mode control of the converter
//
// Operation
// - early select rise while powered down: full down
// - power-down entry happens on select rise alone
// - no glitch guard on full power-down entry
// - wake: select low past 10th falling edge
// - partial wake completes within one dummy frame
// - partial wake: track on first clock edge
// - reset loads normal mode; host runs dummy frame
// - select fall: hold, sample, start, drive output; sample and start only in normal mode
// - 12-bit: track after 13 falls, next rise
// - early select rise aborts, releases output
// - 12-bit: two trailing zeros, release at 16th
// - 10-bit: track after 11 falls, next rise
// - 10-bit: four trailing zeros, release at 16th
// - 14-clock frame: select rise after 14th fall
// - select fall drives first leading zero
// - last bit driven on 15th falling edge
// - late select fall: zero visible, next second
// - normal, rise between 2nd and 10th: partial
// - rise before 2nd fall stays normal
// - rise after 10th: powered, release; abort only before 14th
`timescale 1ns/1ps
module adcsr_top #(
    parameter int RES_BITS = adcsr_pkg::RES_BITS_DEFAULT,
    parameter int FIFO_DEPTH = adcsr_pkg::FIFO_DEPTH_DEFAULT
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic [RES_BITS-1:0] result_data,
    input wire logic result_valid,
    output logic result_ready,
    output logic serial_out,
    output logic serial_oe,
    output logic track_hold,
    output logic sample_start,
    output logic conv_abort,
    output logic [1:0] power_mode,
    output logic analog_on,
    output logic wake_busy
);
    localparam int CW = adcsr_pkg::CNT_W;
    localparam int WCW = $clog2(adcsr_pkg::WAKE_CYCLES + 1);
    localparam logic [WCW-1:0] WAKE_LOAD = WCW'(adcsr_pkg::WAKE_CYCLES);
    localparam logic [CW-1:0] CONV_EDGES = CW'(RES_BITS + adcsr_pkg::LEAD_ZEROS);
    localparam logic [CW-1:0] TRACK_EDGE = CW'(RES_BITS + 1);
    localparam logic [CW-1:0] LOAD_EDGE = CW'(adcsr_pkg::LEAD_ZEROS);

    // ------------------------------------------------------------
    // pin edges
    // ------------------------------------------------------------
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    logic sel_rise;
    logic sel_fall;
    logic sclk_rise;
    logic sclk_fall;

    adcsr_edge #(
        .N(2),
        .INIT(2'h3)
    ) u_edge (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(ce),
        .pin({sel_n, sclk}),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign sel_rise = pin_rise[1];
    assign sel_fall = pin_fall[1];
    assign sclk_rise = pin_rise[0];
    assign sclk_fall = pin_fall[0];

    // ------------------------------------------------------------
    // result buffer
    // ------------------------------------------------------------
    adcsr_stream_if #(.W(RES_BITS)) q ();

    adcsr_fifo #(
        .W(RES_BITS),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(ce),
        .in_valid(result_valid),
        .in_ready(result_ready),
        .in_data(result_data),
        .out(q)
    );

    // ------------------------------------------------------------
    // frame tracking
    // ------------------------------------------------------------
    logic framing;
    logic next_framing;
    logic [CW-1:0] fcnt;
    logic [CW-1:0] next_edge;
    logic frame_fall;
    logic frame_end;
    adcsr_pkg::adcsr_mode_t mode;
    adcsr_pkg::adcsr_mode_t next_mode;
    logic waking;
    logic wake_from_partial;
    logic load_now;
    logic [RES_BITS-1:0] shreg;
    logic [WCW-1:0] wcnt;

    // framing state and falling edges seen so far
    assign frame_fall = framing & sclk_fall & ~sel_rise & ~sel_fall;
    assign frame_end = framing & sel_rise;
    assign next_edge = fcnt + 1'b1;
    assign waking = framing & (mode != adcsr_pkg::ADCSR_NORMAL);
    assign load_now = frame_fall & (next_edge == LOAD_EDGE);

    always_comb begin
        next_framing = framing;
        if (sel_fall) begin
            next_framing = 1'b1;
        end else if (sel_rise) begin
            next_framing = 1'b0;
        end
    end

    // falling-edge counter, frozen once the frame is complete
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            framing <= 1'b0;
            fcnt <= '0;
        end else if (ce) begin
            framing <= next_framing;
            if (sel_fall) begin
                fcnt <= '0;
            end else if (frame_fall && fcnt != adcsr_pkg::FRAME_EDGES) begin
                fcnt <= next_edge;
            end
        end
    end

    // ------------------------------------------------------------
    // power mode decision
    // ------------------------------------------------------------
    // mode chosen where select rises; a held select commits the wake
    always_comb begin
        next_mode = mode;
        if (frame_end) begin
            unique case (mode)
                adcsr_pkg::ADCSR_NORMAL: begin
                    if (fcnt >= adcsr_pkg::GLITCH_EDGE && fcnt < adcsr_pkg::COMMIT_EDGE) begin
                        next_mode = adcsr_pkg::ADCSR_PARTIAL;
                    end
                    // rise before 2nd fall or after 10th stays up
                end
                adcsr_pkg::ADCSR_PARTIAL, adcsr_pkg::ADCSR_FULL: begin
                    if (fcnt < adcsr_pkg::COMMIT_EDGE) begin
                        next_mode = adcsr_pkg::ADCSR_FULL;
                    end
                end
            endcase
        end else if (waking && frame_fall && next_edge == adcsr_pkg::COMMIT_EDGE) begin
            next_mode = adcsr_pkg::ADCSR_NORMAL;
        end
    end

    // mode register and analog supply enable
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mode <= adcsr_pkg::RESET_MODE;
            analog_on <= (adcsr_pkg::RESET_MODE == adcsr_pkg::ADCSR_NORMAL);
        end else if (ce) begin
            mode <= next_mode;
            analog_on <= (next_mode == adcsr_pkg::ADCSR_NORMAL) || next_framing;
        end
    end

    assign power_mode = mode;

    // ------------------------------------------------------------
    // wake timing from full power-down
    // ------------------------------------------------------------
    // busy counts the wake time from the select fall of the dummy frame
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wcnt <= '0;
            wake_busy <= 1'b0;
        end else if (ce) begin
            if (sel_fall && mode == adcsr_pkg::ADCSR_FULL) begin
                wcnt <= WAKE_LOAD;
                wake_busy <= 1'b1;
            end else if (frame_end && next_mode == adcsr_pkg::ADCSR_FULL) begin
                wcnt <= '0; // fell back into full power-down
                wake_busy <= 1'b0;
            end else if (wcnt != '0) begin
                wcnt <= wcnt - 1'b1;
                wake_busy <= (wcnt > WCW'(1)); // still counting after this cycle
            end
        end
    end

    // ------------------------------------------------------------
    // track and hold
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            track_hold <= 1'b0;
            wake_from_partial <= 1'b0;
        end else if (ce) begin
            if (sel_fall) begin
                track_hold <= 1'b1;
                wake_from_partial <= (mode == adcsr_pkg::ADCSR_PARTIAL);
            end else if (frame_end) begin
                track_hold <= (next_mode != adcsr_pkg::ADCSR_NORMAL); // held while down
                wake_from_partial <= 1'b0;
            end else if (framing && wake_from_partial && (sclk_rise || sclk_fall)) begin
                track_hold <= 1'b0;
                wake_from_partial <= 1'b0;
            end else if (framing && sclk_rise && fcnt == TRACK_EDGE) begin
                track_hold <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // serial data output
    // ------------------------------------------------------------
    // a dummy frame shifts zeros and leaves the buffer untouched
    assign q.ready = load_now & ~waking;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            serial_out <= 1'b0;
            serial_oe <= 1'b0;
            shreg <= '0;
        end else if (ce) begin
            if (sel_fall) begin
                serial_oe <= 1'b1;
                serial_out <= 1'b0; // first leading zero
                shreg <= '0;
            end else if (sel_rise) begin
                serial_oe <= 1'b0;
            end else if (frame_fall && fcnt != adcsr_pkg::FRAME_EDGES) begin
                if (next_edge == adcsr_pkg::FRAME_EDGES) begin
                    serial_oe <= 1'b0;
                    serial_out <= 1'b0;
                end else if (load_now) begin
                    // msb first, straight binary
                    if (q.valid && !waking) begin
                        serial_out <= q.data[RES_BITS-1];
                        shreg <= {q.data[RES_BITS-2:0], 1'b0};
                    end else begin
                        serial_out <= 1'b0;
                        shreg <= '0;
                    end
                end else if (next_edge < LOAD_EDGE) begin
                    serial_out <= 1'b0; // second leading zero
                end else begin
                    // zero fill gives the trailing zeros, last on the 15th
                    serial_out <= shreg[RES_BITS-1];
                    shreg <= {shreg[RES_BITS-2:0], 1'b0};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // conversion strobes to the analog core
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sample_start <= 1'b0;
            conv_abort <= 1'b0;
        end else if (ce) begin
            sample_start <= sel_fall && (mode == adcsr_pkg::ADCSR_NORMAL);
            conv_abort <= frame_end && (fcnt < CONV_EDGES);
        end else begin
            sample_start <= 1'b0;
            conv_abort <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    partial_entry_a: assert property (
        frame_end && mode == adcsr_pkg::ADCSR_NORMAL && fcnt >= adcsr_pkg::GLITCH_EDGE
        && fcnt < adcsr_pkg::COMMIT_EDGE |=> mode == adcsr_pkg::ADCSR_PARTIAL && !serial_oe
    ) else $error("partial power-down not entered");

    glitch_guard_a: assert property (
        frame_end && mode == adcsr_pkg::ADCSR_NORMAL && fcnt < adcsr_pkg::GLITCH_EDGE
        |=> mode == adcsr_pkg::ADCSR_NORMAL && analog_on
    ) else $error("glitch powered the core down");

    full_entry_a: assert property (
        frame_end && mode != adcsr_pkg::ADCSR_NORMAL && fcnt < adcsr_pkg::COMMIT_EDGE
        |=> mode == adcsr_pkg::ADCSR_FULL && !analog_on && track_hold
    ) else $error("full power-down not entered");

    stay_up_a: assert property (
        frame_end && mode == adcsr_pkg::ADCSR_NORMAL && fcnt >= adcsr_pkg::COMMIT_EDGE
        |=> mode == adcsr_pkg::ADCSR_NORMAL && !serial_oe
    ) else $error("late select rise changed power");

    abort_release_a: assert property (
        frame_end && fcnt < CONV_EDGES |=> !serial_oe && conv_abort
    ) else $error("abort did not release output");

    frame_start_a: assert property (
        sel_fall |=> serial_oe && !serial_out && track_hold && framing
    ) else $error("select fall did not start frame");

    end_release_a: assert property (
        frame_fall && next_edge == adcsr_pkg::FRAME_EDGES |=> !serial_oe
    ) else $error("output not released at 16th edge");

    wake_commit_a: assert property (
        waking && frame_fall && next_edge == adcsr_pkg::COMMIT_EDGE
        |=> mode == adcsr_pkg::ADCSR_NORMAL
    ) else $error("held select did not wake core");

    track_return_a: assert property (
        framing && !sel_rise && !sel_fall && !wake_from_partial && sclk_rise
        && fcnt == TRACK_EDGE |=> !track_hold
    ) else $error("track not resumed after conversion");

    wake_track_a: assert property (
        framing && wake_from_partial && !sel_rise && !sel_fall && (sclk_rise || sclk_fall)
        |=> !track_hold
    ) else $error("partial wake kept hold");

    wake_time_a: assert property (
        sel_fall && mode == adcsr_pkg::ADCSR_FULL |=> wake_busy [*8]
    ) else $error("wake busy dropped early");

    normal_frame_c: cover property (
        frame_end && mode == adcsr_pkg::ADCSR_NORMAL && fcnt == adcsr_pkg::FRAME_EDGES
    );
    partial_entry_c: cover property (
        frame_end && mode == adcsr_pkg::ADCSR_NORMAL && fcnt == adcsr_pkg::GLITCH_EDGE
    );
    full_entry_c: cover property (
        frame_end && mode == adcsr_pkg::ADCSR_PARTIAL && fcnt < adcsr_pkg::COMMIT_EDGE
    );
    full_wake_c: cover property (
        waking && mode == adcsr_pkg::ADCSR_FULL && next_mode == adcsr_pkg::ADCSR_NORMAL
    );
endmodule

// >>> dv/adcsr_host.sv
// adcsr_host: host serial port model driving select and serial clock
`timescale 1ns/1ps
module adcsr_host (
    input wire logic mclk,
    input wire logic serial_out,
    input wire logic serial_oe,
    input wire logic track_hold,
    input wire logic wake_busy,
    output logic sel_n,
    output logic sclk,
    output logic [15:0] rx_word,
    output logic [15:0] rx_hold,
    output logic rx_busy,
    output logic rx_oe
);
    logic last = 1'b0;
    logic pin;

    // a released data line shows the inverse of the last driven bit
    always_ff @(posedge mclk) begin
        if (serial_oe) begin
            last <= serial_out;
        end
    end
    assign pin = serial_oe ? serial_out : ~last;

    // idle: select high, serial clock parked high between frames
    initial begin
        sel_n = 1'b1;
        sclk = 1'b1;
        rx_word = 16'h0000;
        rx_hold = 16'h0000;
        rx_busy = 1'b0;
        rx_oe = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // one frame of n falls; bit k is read after rise k, just before fall k+1
    task automatic frame(input int n);
        int k;
        rx_word = 16'h0000;
        rx_hold = 16'h0000;
        sel_n = 1'b0;
        for (k = 0; k <= n; k++) begin
            wait_clk(3);
            if (k < 16) begin
                rx_word[15-k] = pin;
                rx_hold[15-k] = track_hold;
            end
            if (k == 0) rx_busy = wake_busy;
            rx_oe = serial_oe;
            if (k < n) begin
                sclk = 1'b0;
                wait_clk(3);
                sclk = 1'b1;
            end
        end
        sel_n = 1'b1;
        wait_clk(4); // quiet time before the next frame
    endtask
endmodule

// >>> dv/adcsr_top_tb_top.sv
// adcsr_top_tb_top: self-checking bench for the serial readout block
`timescale 1ns/1ps
module adcsr_top_tb_top;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic result_valid = 1'b0;
    logic [11:0] result_data = 12'h000;
    logic sel_n, sclk, result_ready, serial_out, serial_oe, track_hold;
    logic sample_start, conv_abort, analog_on, wake_busy, rx_busy, rx_oe;
    logic [1:0] power_mode;
    logic [15:0] rx_word, rx_hold;
    int failures = 0;
    int n_tests = 0;
    int n_start = 0;
    int n_abort = 0;

    // 20 MHz system clock
    initial begin
        forever #25 mclk = ~mclk;
    end

    adcsr_top adcsr_top_inst (.mclk(mclk), .reset_n(reset_n), .ce(ce), .sel_n(sel_n), .sclk(sclk),
        .result_data(result_data), .result_valid(result_valid), .result_ready(result_ready),
        .serial_out(serial_out), .serial_oe(serial_oe), .track_hold(track_hold), .sample_start(sample_start),
        .conv_abort(conv_abort), .power_mode(power_mode), .analog_on(analog_on), .wake_busy(wake_busy));

    adcsr_host adcsr_host_inst (.mclk(mclk), .serial_out(serial_out), .serial_oe(serial_oe),
        .track_hold(track_hold), .wake_busy(wake_busy), .sel_n(sel_n), .sclk(sclk), .rx_word(rx_word),
        .rx_hold(rx_hold), .rx_busy(rx_busy), .rx_oe(rx_oe));

    // count the one-cycle status pulses
    always @(posedge mclk) begin
        if (sample_start === 1'b1) n_start++;
        if (conv_abort === 1'b1) n_abort++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [11:0] word(input int i);
        return 12'h801 + 12'(i) * 12'h1F3;
    endfunction

    // fill the buffer until it refuses, then drain it frame by frame
    task automatic t_fifo();
        int acc;
        int i;
        int s0;
        logic rdy;
        acc = 0;
        for (i = 0; i < 12; i++) begin
            result_data = word(acc);
            result_valid = 1'b1;
            rdy = result_ready;
            tick(1);
            if (rdy !== 1'b1) break;
            acc++;
        end
        result_valid = 1'b0;
        chk(16'(acc), 16'h0008);
        s0 = n_start;
        for (i = 0; i < 8; i++) begin
            adcsr_host_inst.frame(16);
            chk(rx_word, {2'b00, word(i), 2'b00});
            chk(16'({rx_hold[15], rx_hold[3:2]}), 16'h0006);
            chk(16'(rx_oe), 16'h0000);
        end
        adcsr_host_inst.frame(16);
        chk(rx_word, 16'h0000);
        chk(16'(n_start - s0), 16'h0009);
        $display("test fifo done");
    endtask

    // fourteen-fall frame: data complete, output still driven, no abort
    task automatic t_short();
        int a0;
        result_data = 12'hA5C;
        result_valid = 1'b1;
        tick(1);
        result_valid = 1'b0;
        a0 = n_abort;
        adcsr_host_inst.frame(14);
        chk(rx_word[15:2], 14'h0A5C);
        chk(16'(rx_oe), 16'h0001);
        chk(16'(serial_oe), 16'h0000);
        chk(16'(n_abort - a0), 16'h0000);
        $display("test short done");
    endtask

    // power modes: late abort, partial, full, both wake paths, glitch
    task automatic t_power();
        int a0;
        a0 = n_abort;
        adcsr_host_inst.frame(12);
        chk(16'(power_mode), 16'(adcsr_pkg::ADCSR_NORMAL));
        chk(16'({n_abort - a0, serial_oe}), 16'h0002);
        adcsr_host_inst.frame(5);
        chk(16'(power_mode), 16'(adcsr_pkg::ADCSR_PARTIAL));
        chk(16'(serial_oe), 16'h0000);
        adcsr_host_inst.frame(1);
        chk(16'(power_mode), 16'(adcsr_pkg::ADCSR_FULL));
        chk(16'(analog_on), 16'h0000);
        adcsr_host_inst.frame(16);
        chk(16'(rx_busy), 16'h0001);
        chk(16'({analog_on, power_mode}), 16'h0004);
        adcsr_host_inst.frame(5);
        adcsr_host_inst.frame(16);
        chk(16'(rx_hold[14]), 16'h0000);
        chk(16'(power_mode), 16'(adcsr_pkg::ADCSR_NORMAL));
        adcsr_host_inst.frame(1);
        chk(16'(power_mode), 16'(adcsr_pkg::ADCSR_NORMAL));
        $display("test power done");
    endtask

    // clock enable low: a push and a power-down frame leave no trace
    task automatic t_ce();
        int s0;
        s0 = n_start;
        ce = 1'b0;
        result_data = 12'h3C6;
        result_valid = 1'b1;
        tick(3);
        result_valid = 1'b0;
        adcsr_host_inst.frame(5);
        chk(16'({n_start - s0, power_mode}), 16'h0000);
        chk(16'(rx_oe), 16'h0000);
        ce = 1'b1;
        result_data = 12'h5A1;
        result_valid = 1'b1;
        tick(1);
        result_valid = 1'b0;
        adcsr_host_inst.frame(16);
        chk(rx_word, 16'h1684);
        $display("test ce done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (100000) @(posedge mclk);
        failures++;
        end_of_test();
    end

    // reset for two cycles, then the scenarios
    initial begin
        tick(2);
        reset_n = 1'b1;
        tick(2);
        t_fifo();
        t_short();
        t_power();
        t_ce();
        end_of_test();
    end
endmodule
